// >>> rtl/flash_param_check_result.v
// parameter checker and result reporter for flash programming and erasure.
// assumes the cpu hands parameters in on plain ports, all synchronous to
// i_core_clk, and that an external cell engine does the real cell work.
//
// Functional notes
// - a source start address inside flash sets program result bit 2, else it is 0.
// - a destination start address outside flash sets program result bit 1.
// - a destination whose low byte is neither 00 nor 80 hex also sets program result bit 1.
// - program result bit 0 is 0 for a clean finish and 1 for an abnormal one.
// - a block number outside the valid range flags a block selection error.
// - erase result bit 7 always reads 0.
// - erase result bit 6 is 1 when the write enable pin is low or the protect latch is set.
// - erase result bit 4 is 1 when the key register is not 5a hex.
// - erase result bit 3 is 1 when the block number is outside the user area.
// - erase result bit 0 is 0 for a normal end and 1 when an error occurred.
`timescale 1ns/100ps
`include "flash_param_check_map.vh"
module flash_param_check_result (
    // clock and reset
    input wire i_core_clk,
    input wire i_rst,
    // requests from the cpu
    input wire i_prog_start,
    input wire i_erase_start,
    input wire [31:0] i_src_addr,
    input wire [31:0] i_dst_addr,
    input wire [31:0] i_erase_block_param,
    input wire [7:0] i_flash_key_reg,
    // protection state
    input wire i_write_enable_pin,
    input wire i_protect_error_latch,
    // cell engine
    output wire o_cell_prog_start,
    output wire o_cell_erase_start,
    output wire [31:0] o_cell_src_addr,
    output wire [31:0] o_cell_dst_addr,
    output wire [9:0] o_cell_block,
    input wire i_cell_done,
    input wire i_cell_err,
    // results
    output wire [7:0] o_program_result_byte,
    output wire [7:0] o_erase_result_byte,
    output wire o_busy,
    output wire o_done
);
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg is_erase_q;
    reg [31:0] src_q;
    reg [31:0] dst_q;
    reg [31:0] block_param_q;
    reg [7:0] key_q;
    reg mode_err_q;
    reg [7:0] prog_res_q;
    reg [7:0] erase_res_q;
    reg done_q;
    wire src_in_flash;
    wire dst_in_flash;
    wire src_err;
    wire dst_err;
    wire key_err;
    wire block_err;
    wire any_err;
    wire [7:0] prog_chk;
    wire [7:0] erase_chk;
    wire take;
    wire finish;
    wire [7:0] cell_res;
    wire [7:0] fail_res;
    wire [7:0] used_mask;
    wire [7:0] next_res;
    genvar bit_idx;

    flash_area_check #(
        .BASE(`FLASH_BASE),
        .LIMIT(`FLASH_LIMIT)
    ) u_src_chk (
        .i_addr(src_q),
        .o_in_flash(src_in_flash)
    );

    flash_area_check #(
        .BASE(`FLASH_BASE),
        .LIMIT(`FLASH_LIMIT)
    ) u_dst_chk (
        .i_addr(dst_q),
        .o_in_flash(dst_in_flash)
    );

    assign take = (state_q == `ST_IDLE) && (i_prog_start || i_erase_start);

    assign src_err = src_in_flash;
    assign dst_err = !dst_in_flash ||
        ((dst_q[7:0] != `ALIGN_LOW_A) && (dst_q[7:0] != `ALIGN_LOW_B));
    assign key_err = (key_q != `FLASH_KEY_OK);
    // padding bits set also count as a bad selection, so any value with a bit set above bit 9 is refused
    assign block_err = (block_param_q[31:`BLOCK_PAD_LSB] != 22'h000000) ||
        (block_param_q[`BLOCK_FIELD_MSB:0] > `BLOCK_LAST);

    // check-stage result bytes; bit 0 and bit 5 are filled in later
    assign prog_chk = {1'b0, mode_err_q, 1'b0, key_err, 1'b0, src_err, dst_err, 1'b0};
    assign erase_chk = {1'b0, mode_err_q, 1'b0, key_err, block_err, 2'b00, 1'b0};
    assign any_err = is_erase_q ? (erase_chk != 8'h00) : (prog_chk != 8'h00);

    // a result is written either by a failed check or by the cell engine's answer, never both
    assign finish = ((state_q == `ST_CHECK) && any_err) ||
        ((state_q == `ST_WAIT) && i_cell_done);
    assign fail_res = (is_erase_q ? erase_chk : prog_chk) | 8'h01;
    assign cell_res = {2'b00, i_cell_err, 4'h0, i_cell_err};
    assign used_mask = is_erase_q ? `RES_ERASE_USED : `RES_PROG_USED;

    // unused bits are masked per bit, so a check of the other kind can never leak into a byte
    generate
        for (bit_idx = 0; bit_idx < 8; bit_idx = bit_idx + 1) begin : g_res_bit
            assign next_res[bit_idx] = used_mask[bit_idx] &&
                ((state_q == `ST_CHECK) ? fail_res[bit_idx] : cell_res[bit_idx]);
        end
    endgenerate

    always @* begin
        state_d = state_q;
        case (state_q)
            `ST_IDLE: begin
                if (i_prog_start || i_erase_start) begin
                    state_d = `ST_CHECK;
                end
            end
            `ST_CHECK: begin
                if (any_err) begin
                    state_d = `ST_IDLE;
                end else begin
                    state_d = `ST_LAUNCH;
                end
            end
            `ST_LAUNCH: begin
                state_d = `ST_WAIT;
            end
            `ST_WAIT: begin
                if (i_cell_done) begin
                    state_d = `ST_IDLE;
                end
            end
            default: begin
                state_d = `ST_IDLE;
            end
        endcase
    end

    // state and the one-cycle completion strobe
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= `ST_IDLE;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            done_q <= finish;
        end
    end

    // parameters are frozen at take, so the cpu may reuse its registers while a check runs
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            is_erase_q <= 1'b0;
            src_q <= 32'h0000_0000;
            dst_q <= 32'h0000_0000;
            block_param_q <= 32'h0000_0000;
            key_q <= 8'h00;
            mode_err_q <= 1'b0;
        end else if (take) begin
            // program wins if both starts arrive together
            is_erase_q <= !i_prog_start;
            src_q <= i_src_addr;
            dst_q <= i_dst_addr;
            block_param_q <= i_erase_block_param;
            key_q <= i_flash_key_reg;
            mode_err_q <= !i_write_enable_pin || i_protect_error_latch;
        end
    end

    // each result byte only moves when an operation of its own kind finishes
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            prog_res_q <= `RES_RESET;
            erase_res_q <= `RES_RESET;
        end else if (finish) begin
            if (is_erase_q) begin
                erase_res_q <= next_res;
            end else begin
                prog_res_q <= next_res;
            end
        end
    end

    // cell engine only sees a start after a clean check
    assign o_cell_prog_start = (state_q == `ST_LAUNCH) && !is_erase_q;
    assign o_cell_erase_start = (state_q == `ST_LAUNCH) && is_erase_q;
    assign o_cell_src_addr = src_q;
    assign o_cell_dst_addr = dst_q;
    assign o_cell_block = block_param_q[`BLOCK_FIELD_MSB:0];
    assign o_program_result_byte = prog_res_q;
    assign o_erase_result_byte = erase_res_q;
    assign o_busy = (state_q != `ST_IDLE);
    assign o_done = done_q;
endmodule // flash_param_check_result

// >>> pkg/flash_param_check_map.vh
// constants for the flash parameter checker: result byte fields, key value,
// block range and the default flash address window.
// assumes only that the includer is plain verilog-2005.
`ifndef FLASH_PARAM_CHECK_MAP_VH
`define FLASH_PARAM_CHECK_MAP_VH

// result byte field positions, shared by program and erase results
`define RES_UNUSED7_BIT 7
`define RES_MODE_ERR_BIT 6
`define RES_EXEC_ERR_BIT 5
`define RES_KEY_ERR_BIT 4
`define RES_BLOCK_ERR_BIT 3
`define RES_SRC_ERR_BIT 2
`define RES_DST_ERR_BIT 1
`define RES_SUCCESS_FAIL_BIT 0
`define RES_RESET 8'h00

// bits that each result kind defines; every other bit always reads 0
`define RES_PROG_USED 8'h77
`define RES_ERASE_USED 8'h79

// erase block parameter layout
`define BLOCK_FIELD_MSB 9
`define BLOCK_PAD_LSB 10
`define BLOCK_FIRST 10'h000
`define BLOCK_LAST 10'h017

// key that unlocks programming and erasure
`define FLASH_KEY_OK 8'h5a

// destination must sit on a 128-byte boundary
`define ALIGN_LOW_A 8'h00
`define ALIGN_LOW_B 8'h80

// flash address window, plain defaults
`define FLASH_BASE 32'h0000_0000
`define FLASH_LIMIT 32'h0007_ffff

// state codes
`define ST_IDLE 2'h0
`define ST_CHECK 2'h1
`define ST_LAUNCH 2'h2
`define ST_WAIT 2'h3

`endif

// >>> rtl/flash_area_check.v
// address window compare: tells whether an address lies inside flash.
// assumes base and limit are inclusive and base is not above limit.
`timescale 1ns/100ps
module flash_area_check #(
    parameter [31:0] BASE = 32'h0000_0000,
    parameter [31:0] LIMIT = 32'h0007_ffff
) (
    // address under test
    input wire [31:0] i_addr,
    // result
    output wire o_in_flash
);
    assign o_in_flash = (i_addr >= BASE) && (i_addr <= LIMIT);
endmodule // flash_area_check

// >>> bench/flash_param_check_assertions.sv
// concurrent checks on the flash parameter checker ports
// assumes the default flash window and a cell engine that answers in wait
`timescale 1ns/100ps
`include "flash_param_check_map.vh"
module flash_param_check_assertions (
    // clock, reset and requests
    input wire i_core_clk, i_rst, i_prog_start, i_erase_start, i_write_enable_pin, i_protect_error_latch,
    input wire [31:0] i_src_addr, i_dst_addr,
    input wire [7:0] i_flash_key_reg,
    // results and cell engine
    input wire [7:0] o_program_result_byte, o_erase_result_byte,
    input wire o_cell_prog_start, o_cell_erase_start, i_cell_done, i_cell_err, o_busy, o_done
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    wire [7:0] pr = o_program_result_byte;
    wire [7:0] er = o_erase_result_byte;
    wire tp = i_prog_start && !o_busy;
    wire te = i_erase_start && !i_prog_start && !o_busy;
    property p_bit7; !pr[7] && !er[7]; endproperty
    a_bit7: assert property (p_bit7) else $error("bit 7 set");
    property p_src; tp && i_src_addr <= `FLASH_LIMIT |-> ##2 o_done && pr[2] && pr[0]; endproperty
    a_src: assert property (p_src) else $error("source error missing");
    property p_dst; tp && i_dst_addr[6:0] != 7'h0 |-> ##2 o_done && pr[1] && pr[0]; endproperty
    a_dst: assert property (p_dst) else $error("alignment error missing");
    property p_mode; te && !(i_write_enable_pin && !i_protect_error_latch) |-> ##2 o_done && er[6]; endproperty
    a_mode: assert property (p_mode) else $error("mode error missing");
    property p_key; te && i_flash_key_reg != `FLASH_KEY_OK |-> ##2 er[4] && er[0]; endproperty
    a_key: assert property (p_key) else $error("key error missing");
    property p_skip; te && i_flash_key_reg != `FLASH_KEY_OK |-> ##1 !o_cell_erase_start [*2]; endproperty
    a_skip: assert property (p_skip) else $error("erase started despite error");
    property p_esf; o_cell_erase_start ##1 i_cell_done |=> o_done && er[0] == $past(i_cell_err); endproperty
    a_esf: assert property (p_esf) else $error("erase pass fail wrong");
    property p_psf; o_cell_prog_start ##1 i_cell_done |=> o_done && pr[0] == $past(i_cell_err); endproperty
    a_psf: assert property (p_psf) else $error("program pass fail wrong");
endmodule // flash_param_check_assertions
bind flash_param_check_result flash_param_check_assertions chk (.*);

// >>> bench/testbench.sv
// self-checking bench for the flash parameter checker
// assumes the checker file binds its assertions to uut
`timescale 1ns/100ps
module testbench;
    reg i_core_clk = 0, i_rst = 1, i_prog_start = 0, i_erase_start = 0, i_cell_done = 0, i_cell_err = 0;
    reg i_write_enable_pin = 0, i_protect_error_latch = 0, both = 0;
    reg [31:0] i_src_addr = 0, i_dst_addr = 0, i_erase_block_param = 0;
    reg [7:0] i_flash_key_reg = 0;
    wire o_cell_prog_start, o_cell_erase_start, o_busy, o_done;
    wire [31:0] o_cell_src_addr, o_cell_dst_addr;
    wire [9:0] o_cell_block;
    wire [7:0] o_program_result_byte, o_erase_result_byte;
    int failures = 0, n_compared = 0, cycles = 0;
    always #4 i_core_clk = ~i_core_clk;
    flash_param_check_result uut (.*);
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            failures++;
            end_sim;
        end
    end
    // the cell engine answers on the cycle after its start pulse
    task op(input bit pe, input [31:0] s, d, p, input [7:0] k, input bit we, fl, ce, input [7:0] exp);
        bit got, bad;
        logic [7:0] r;
        begin
            got = 0;
            bad = 0;
            @(posedge i_core_clk);
            i_prog_start <= pe;
            i_erase_start <= !pe || both;
            i_src_addr <= s;
            i_dst_addr <= d;
            i_erase_block_param <= p;
            i_flash_key_reg <= k;
            i_write_enable_pin <= we;
            i_protect_error_latch <= fl;
            i_cell_err <= ce;
            for (int n = 0; n < 20 && !got; n++) begin
                @(posedge i_core_clk);
                i_prog_start <= 0;
                i_erase_start <= 0;
                i_cell_done <= o_cell_prog_start | o_cell_erase_start;
                // the engine must be handed exactly the request that was frozen at take
                if ((o_cell_prog_start || o_cell_erase_start) && (o_cell_block !== p[9:0] ||
                    o_cell_src_addr !== s || o_cell_dst_addr !== d || o_cell_prog_start !== pe))
                    bad = 1;
                if (n == 1 && o_busy !== 1'b1)
                    bad = 1;
                got = o_done;
            end
            r = pe ? o_program_result_byte : o_erase_result_byte;
            n_compared++;
            if (!got || r !== exp || o_busy !== 1'b0 || bad) begin
                failures++;
                $display("MISMATCH %0t result %h", $time, r);
            end
            $display("test done, result %h", r);
        end
    endtask
    initial begin
        repeat (2) @(posedge i_core_clk);
        i_rst <= 0;
        op(1, 32'h00100000, 32'h00000080, 0, 8'h5a, 1, 0, 0, 8'h00);
        op(1, 32'h00001000, 32'h00000100, 0, 8'h5a, 1, 0, 0, 8'h05);
        op(1, 32'h00100000, 32'h00080000, 0, 8'h5a, 1, 0, 0, 8'h03);
        op(1, 32'h00100000, 32'h00000140, 0, 8'h5a, 1, 0, 0, 8'h03);
        op(1, 32'h00100000, 32'h0007ff80, 0, 8'h5a, 1, 0, 1, 8'h21);
        op(0, 0, 0, 32'h17, 8'h5a, 1, 0, 0, 8'h00);
        op(0, 0, 0, 32'h18, 8'h5a, 1, 0, 0, 8'h09);
        op(0, 0, 0, 32'h400, 8'h5a, 1, 0, 0, 8'h09);
        op(0, 0, 0, 32'h0, 8'h5b, 1, 0, 0, 8'h11);
        op(0, 0, 0, 32'h5, 8'h5a, 0, 0, 0, 8'h41);
        op(0, 0, 0, 32'h5, 8'h5a, 1, 1, 0, 8'h41);
        op(0, 0, 0, 32'h5, 8'h5a, 1, 0, 1, 8'h21);
        op(1, 32'h00100000, 32'h00000080, 0, 8'h5a, 0, 0, 0, 8'h41);
        both = 1;
        op(1, 32'h00100000, 32'h00000080, 0, 8'h5b, 1, 0, 0, 8'h11);
        both = 0;
        n_compared++;
        if (o_erase_result_byte !== 8'h21) begin
            failures++;
            $display("MISMATCH %0t erase result moved", $time);
        end
        $display("test done, program taken over erase");
        end_sim;
    end
endmodule // testbench
